// *** hdl/grl_pkg.sv ***
// Package: bus command codes, address defaults and timing constants
package grl_pkg;
  localparam logic [4:0] DEFAULT_ADDR = 5'h1B;
  localparam logic [2:0] TALK_GRP = 3'h2;
  localparam logic [2:0] LISTEN_GRP = 3'h1;
  localparam logic [2:0] UNIV_GRP = 3'h1;
  localparam logic [2:0] ADDR_GRP = 3'h0;
  localparam logic [4:0] UNADDR_CODE = 5'h1F;
  localparam logic [4:0] CMD_GTL = 5'h01;
  localparam logic [4:0] CMD_SDC = 5'h04;
  localparam logic [4:0] CMD_GET = 5'h08;
  localparam logic [4:0] CMD_LLO = 5'h11;
  localparam logic [4:0] CMD_DCL = 5'h14;
  localparam logic [4:0] CMD_SPE = 5'h18;
  localparam logic [4:0] CMD_SPD = 5'h19;
  localparam logic [7:0] EOS_CR = 8'h0D;
  localparam logic [7:0] EOS_LF = 8'h0A;
  localparam int CLK_HZ = 20000000;
  localparam int IFC_MIN_NS = 100000;
  localparam int IFC_CYCLES = (IFC_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  typedef enum logic [1:0] {
    RL_LOCAL = 2'b00,
    RL_REMOTE = 2'b01,
    RL_LOCAL_LOCKED = 2'b10,
    RL_REMOTE_LOCKED = 2'b11
  } grl_rl_state_t;
endpackage : grl_pkg

// *** hdl/grl_decode_if.sv ***
// Interface: decoded command strobes between decoder and core
`timescale 1ns/100ps
interface grl_decode_if;
  logic cmd_valid;
  logic my_listen;
  logic my_talk;
  logic unlisten;
  logic untalk;
  logic other_talk;
  logic gtl;
  logic sdc;
  logic get;
  logic llo;
  logic dcl;
  logic spe;
  logic spd;
  modport dec (output cmd_valid, my_listen, my_talk, unlisten, untalk, other_talk,
               gtl, sdc, get, llo, dcl, spe, spd);
  modport core (input cmd_valid, my_listen, my_talk, unlisten, untalk, other_talk,
                gtl, sdc, get, llo, dcl, spe, spd);
endinterface : grl_decode_if

// *** hdl/grl_cmd_decode.sv ***
// Command byte decoder for bytes taken while ATN is true
`timescale 1ns/100ps
module grl_cmd_decode (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Sync reset
  input wire logic i_take, // Command byte strobe
  input wire logic [7:0] i_byte, // Command byte
  input wire logic [4:0] i_addr, // Own primary address
  grl_decode_if.dec dec // Decoded strobes
);
  wire [2:0] grp = i_byte[7:5] & 3'h3;
  wire [4:0] code = i_byte[4:0];
  wire is_lag = i_take && (grp == grl_pkg::LISTEN_GRP);
  wire is_tag = i_take && (grp == grl_pkg::TALK_GRP);
  wire is_ucg = i_take && (i_byte[6:4] == grl_pkg::UNIV_GRP);
  wire is_acg = i_take && (i_byte[6:4] == grl_pkg::ADDR_GRP);
  wire [4:0] ucode = {1'b1, i_byte[3:0]};
  logic v_reg;
  logic [11:0] s_reg;
  logic [11:0] s_next;
  always_comb begin
    s_next = '0;
    s_next[0] = is_lag && (code == i_addr);
    s_next[1] = is_tag && (code == i_addr);
    s_next[2] = is_lag && (code == grl_pkg::UNADDR_CODE);
    s_next[3] = is_tag && (code == grl_pkg::UNADDR_CODE);
    s_next[4] = is_tag && (code != i_addr) && (code != grl_pkg::UNADDR_CODE);
    s_next[5] = is_acg && ({1'b0, i_byte[3:0]} == grl_pkg::CMD_GTL);
    s_next[6] = is_acg && ({1'b0, i_byte[3:0]} == grl_pkg::CMD_SDC);
    s_next[7] = is_acg && ({1'b0, i_byte[3:0]} == grl_pkg::CMD_GET);
    s_next[8] = is_ucg && (ucode == grl_pkg::CMD_LLO);
    s_next[9] = is_ucg && (ucode == grl_pkg::CMD_DCL);
    s_next[10] = is_ucg && (ucode == grl_pkg::CMD_SPE);
    s_next[11] = is_ucg && (ucode == grl_pkg::CMD_SPD);
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_reg <= '0;
      v_reg <= 1'b0;
    end else begin
      s_reg <= s_next;
      v_reg <= i_take;
    end
  end
  assign dec.cmd_valid = v_reg;
  assign dec.my_listen = s_reg[0];
  assign dec.my_talk = s_reg[1];
  assign dec.unlisten = s_reg[2];
  assign dec.untalk = s_reg[3];
  assign dec.other_talk = s_reg[4];
  assign dec.gtl = s_reg[5];
  assign dec.sdc = s_reg[6];
  assign dec.get = s_reg[7];
  assign dec.llo = s_reg[8];
  assign dec.dcl = s_reg[9];
  assign dec.spe = s_reg[10];
  assign dec.spd = s_reg[11];
endmodule : grl_cmd_decode

// *** hdl/grl_remote_local.sv ***
// Remote/local control core for the instrument's parallel bus port
`timescale 1ns/100ps
module grl_remote_local (
  input wire logic I_SYS_CLK, // System clock, 20 MHz
  input wire logic I_RST, // Sync reset, active high
  input wire logic I_ATN, // Attention pin, true high
  input wire logic I_REN, // Remote enable pin, true high
  input wire logic I_IFC, // Interface clear pin, true high
  input wire logic I_CMD_TAKE, // Byte accepted by handshake, pulse
  input wire logic [7:0] I_DIO, // Byte from bus
  input wire logic I_ADDR_LOAD, // Load new address from menu, pulse
  input wire logic [4:0] I_ADDR_NEW, // New address value
  input wire logic [11:0] I_PANEL_KEYS, // Front-panel key pulses, bit 0 local
  input wire logic I_LANG_ENTER, // Language menu enter, pulse
  input wire logic I_LANG_PICK, // Picked language, 1 legacy set
  input wire logic I_TRIG_SRC_BUS, // Bus trigger is programmed source
  input wire logic [7:0] I_STATUS_BYTE, // Status byte from status logic
  input wire logic [7:0] I_RESP_DATA, // Response byte from formatter
  input wire logic I_RESP_VALID, // Response byte offered
  input wire logic I_TX_READY, // Bus handshake can send now
  output logic O_RESP_READY, // Response byte accepted
  output logic [7:0] O_TX_DATA, // Byte to drive on bus
  output logic O_TX_VALID, // Byte offered to bus handshake
  output logic [11:0] O_KEYS_EN, // Key pulses passed to panel logic
  output logic O_REMOTE_INDICATOR, // Remote annunciator
  output logic O_TALK_INDICATOR, // Talk annunciator
  output logic O_LISTEN_INDICATOR, // Listen annunciator
  output logic O_LOCKOUT, // Lockout in effect
  output logic O_SPOLL, // Serial poll mode
  output logic O_DEV_CLEAR, // Clear queues, deferred work pulse
  output logic O_TRIGGER, // Trigger event pulse
  output logic O_LEGACY_DEVICE_COMMAND_SET, // Language, 1 legacy set
  output logic O_POWERON_RESET, // Power-on default reset pulse
  output logic [4:0] O_ADDR // Current primary address
);
  logic atn_s1_reg, atn_reg, ren_s1_reg, ren_reg, ifc_s1_reg, ifc_reg;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      atn_s1_reg <= 1'b0;
      atn_reg <= 1'b0;
      ren_s1_reg <= 1'b0;
      ren_reg <= 1'b0;
      ifc_s1_reg <= 1'b0;
      ifc_reg <= 1'b0;
    end else begin
      atn_s1_reg <= I_ATN;
      atn_reg <= atn_s1_reg;
      ren_s1_reg <= I_REN;
      ren_reg <= ren_s1_reg;
      ifc_s1_reg <= I_IFC;
      ifc_reg <= ifc_s1_reg;
    end
  end

  // Address held across resets other than I_RST, like non-volatile store
  logic [4:0] addr_reg;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) addr_reg <= grl_pkg::DEFAULT_ADDR;
    else if (I_ADDR_LOAD) addr_reg <= I_ADDR_NEW;
  end
  assign O_ADDR = addr_reg;

  grl_decode_if dif ();
  wire take_cmd = I_CMD_TAKE && atn_reg;
  grl_cmd_decode u_dec (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_take(take_cmd),
    .i_byte(I_DIO),
    .i_addr(addr_reg),
    .dec(dif)
  );

  // Interface clear counted; bus too noisy to trust shorter pulses
  localparam int IFC_W = $clog2(grl_pkg::IFC_CYCLES + 1);
  localparam logic [IFC_W-1:0] IFC_LAST = IFC_W'(grl_pkg::IFC_CYCLES - 1);
  logic [IFC_W-1:0] ifc_cnt_reg;
  logic ifc_seen_reg;
  wire ifc_hit = ifc_reg && (ifc_cnt_reg == IFC_LAST) && !ifc_seen_reg;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || !ifc_reg) begin
      ifc_cnt_reg <= '0;
      ifc_seen_reg <= 1'b0;
    end else if (ifc_hit) begin
      ifc_seen_reg <= 1'b1;
    end else if (!ifc_seen_reg) begin
      ifc_cnt_reg <= ifc_cnt_reg + 1'b1;
    end
  end

  // Language change restarts the instrument; same pick is a no-op
  logic lang_reg, por_reg;
  wire lang_change = I_LANG_ENTER && (I_LANG_PICK != lang_reg);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      lang_reg <= 1'b0;
      por_reg <= 1'b0;
    end else begin
      if (lang_change) lang_reg <= I_LANG_PICK;
      por_reg <= lang_change;
    end
  end
  assign O_LEGACY_DEVICE_COMMAND_SET = lang_reg;
  assign O_POWERON_RESET = por_reg;
  wire soft_rst = I_RST || por_reg;

  // Listener and talker addressing
  logic lacs_reg, tacs_reg, spoll_reg;
  wire lacs_next = ifc_hit ? 1'b0 :
                   dif.my_listen ? 1'b1 :
                   (dif.unlisten || dif.my_talk) ? 1'b0 : lacs_reg;
  wire tacs_next = ifc_hit ? 1'b0 :
                   dif.my_talk ? 1'b1 :
                   (dif.untalk || dif.my_listen || dif.other_talk) ? 1'b0 : tacs_reg;
  wire spoll_next = ifc_hit ? 1'b0 : dif.spe ? 1'b1 : dif.spd ? 1'b0 : spoll_reg;

  // Remote/local state machine
  grl_pkg::grl_rl_state_t rl_reg, rl_next;
  wire local_key = I_PANEL_KEYS[0];
  wire to_remote = dif.my_listen && ren_reg;
  always_comb begin
    rl_next = rl_reg;
    case (rl_reg)
      grl_pkg::RL_LOCAL: begin
        if (dif.llo) rl_next = grl_pkg::RL_LOCAL_LOCKED;
        if (to_remote) rl_next = dif.llo ? grl_pkg::RL_REMOTE_LOCKED : grl_pkg::RL_REMOTE;
      end
      grl_pkg::RL_REMOTE: begin
        if (dif.llo) rl_next = grl_pkg::RL_REMOTE_LOCKED;
        else if (local_key || (dif.gtl && lacs_reg)) rl_next = grl_pkg::RL_LOCAL;
      end
      grl_pkg::RL_LOCAL_LOCKED: begin
        if (to_remote) rl_next = grl_pkg::RL_REMOTE_LOCKED;
        else if (dif.gtl && lacs_reg) rl_next = grl_pkg::RL_LOCAL;
      end
      grl_pkg::RL_REMOTE_LOCKED: begin
        if (dif.gtl && lacs_reg) rl_next = grl_pkg::RL_LOCAL;
      end
      default: rl_next = grl_pkg::RL_LOCAL;
    endcase
    if (ifc_hit) begin
      rl_next = (rl_next == grl_pkg::RL_REMOTE_LOCKED) ? grl_pkg::RL_LOCAL_LOCKED
                : (rl_next == grl_pkg::RL_REMOTE) ? grl_pkg::RL_LOCAL : rl_next;
    end
    if (!ren_reg) rl_next = grl_pkg::RL_LOCAL;
  end

  // Clear and trigger pulses; interface clear touches no instrument state
  logic dclr_reg, trig_reg;
  wire dclr_next = dif.dcl || (dif.sdc && lacs_reg);
  wire trig_next = dif.get && lacs_reg && I_TRIG_SRC_BUS;
  always_ff @(posedge I_SYS_CLK) begin
    if (soft_rst) begin
      rl_reg <= grl_pkg::RL_LOCAL;
      lacs_reg <= 1'b0;
      tacs_reg <= 1'b0;
      spoll_reg <= 1'b0;
      dclr_reg <= 1'b0;
      trig_reg <= 1'b0;
    end else begin
      rl_reg <= rl_next;
      lacs_reg <= lacs_next;
      tacs_reg <= tacs_next;
      spoll_reg <= spoll_next;
      dclr_reg <= dclr_next;
      trig_reg <= trig_next;
    end
  end

  wire in_remote = rl_reg[0];
  wire locked = rl_reg[1];
  assign O_REMOTE_INDICATOR = in_remote;
  assign O_TALK_INDICATOR = tacs_reg;
  assign O_LISTEN_INDICATOR = lacs_reg;
  assign O_LOCKOUT = locked;
  assign O_SPOLL = spoll_reg;
  assign O_DEV_CLEAR = dclr_reg;
  assign O_TRIGGER = trig_reg;

  // Key gating; local key dies under lockout even from local state
  logic [11:0] keys_reg;
  wire [11:0] key_ok;
  genvar k;
  generate
    for (k = 0; k < 12; k++) begin : g_key
      if (k == 0) begin : g_local
        assign key_ok[k] = !locked;
      end else begin : g_other
        assign key_ok[k] = !in_remote && !locked;
      end
    end
  endgenerate
  always_ff @(posedge I_SYS_CLK) begin
    if (soft_rst) keys_reg <= '0;
    else keys_reg <= I_PANEL_KEYS & key_ok;
  end
  assign O_KEYS_EN = keys_reg;

  // Talker path: status byte in poll mode, else response stream
  logic [7:0] tx_reg;
  logic tx_v_reg;
  wire talk_now = tacs_reg && !atn_reg;
  wire tx_take = tx_v_reg && I_TX_READY;
  wire load_resp = talk_now && !spoll_reg && I_RESP_VALID && (!tx_v_reg || tx_take);
  wire load_stb = talk_now && spoll_reg && !tx_v_reg;
  always_ff @(posedge I_SYS_CLK) begin
    if (soft_rst || dclr_reg || !talk_now) begin
      tx_v_reg <= 1'b0;
      tx_reg <= '0;
    end else if (load_stb) begin
      tx_v_reg <= 1'b1;
      tx_reg <= I_STATUS_BYTE;
    end else if (load_resp) begin
      tx_v_reg <= 1'b1;
      tx_reg <= I_RESP_DATA;
    end else if (tx_take) begin
      tx_v_reg <= 1'b0;
    end
  end
  assign O_RESP_READY = load_resp;
  assign O_TX_DATA = tx_reg;
  assign O_TX_VALID = tx_v_reg;
endmodule : grl_remote_local

// *** tb/grl_props.sv ***
// Checker: port-level properties of the remote/local control block
`timescale 1ns/100ps
module grl_props (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_IFC,
  input wire logic I_CMD_TAKE,
  input wire logic [7:0] I_DIO,
  input wire logic I_ADDR_LOAD,
  input wire logic [11:0] I_PANEL_KEYS,
  input wire logic I_LANG_ENTER,
  input wire logic I_LANG_PICK,
  input wire logic I_TRIG_SRC_BUS,
  input wire logic [11:0] O_KEYS_EN,
  input wire logic O_REMOTE_INDICATOR,
  input wire logic O_TALK_INDICATOR,
  input wire logic O_LISTEN_INDICATOR,
  input wire logic O_LOCKOUT,
  input wire logic O_SPOLL,
  input wire logic O_DEV_CLEAR,
  input wire logic O_TRIGGER,
  input wire logic O_LEGACY_DEVICE_COMMAND_SET,
  input wire logic O_POWERON_RESET,
  input wire logic [4:0] O_ADDR
);
  logic [11:0] ifc_cnt_reg;
  wire logic lang_diff = I_LANG_PICK != O_LEGACY_DEVICE_COMMAND_SET;
  // Margin covers the two-flop pin synchroniser and the clearing edge
  wire logic ifc_done = ifc_cnt_reg >= 12'(grl_pkg::IFC_CYCLES + 4);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || !I_IFC) ifc_cnt_reg <= 12'h000;
    else if (!ifc_done) ifc_cnt_reg <= ifc_cnt_reg + 12'h001;
  end
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  sequence s_por;
    O_POWERON_RESET ##1 !O_POWERON_RESET;
  endsequence
  property p_remote_entry;
    $rose(O_REMOTE_INDICATOR) |-> $past(I_CMD_TAKE, 2) && $past(I_DIO, 2) == {3'h1, O_ADDR};
  endproperty
  a_remote_entry: assert property (p_remote_entry) else $error("remote without listen");
  property p_keys_remote;
    $past(O_REMOTE_INDICATOR) |-> O_KEYS_EN[11:1] == 11'h000;
  endproperty
  a_keys_remote: assert property (p_keys_remote) else $error("key passed in remote");
  property p_keys_local;
    $past(!O_REMOTE_INDICATOR && !O_LOCKOUT && !O_POWERON_RESET) |->
      O_KEYS_EN == $past(I_PANEL_KEYS);
  endproperty
  a_keys_local: assert property (p_keys_local) else $error("key lost in local");
  property p_keys_lock;
    $past(O_LOCKOUT) |-> O_KEYS_EN == 12'h000;
  endproperty
  a_keys_lock: assert property (p_keys_lock) else $error("key passed in lockout");
  property p_ifc_idle;
    ifc_done |-> !O_TALK_INDICATOR && !O_LISTEN_INDICATOR && !O_REMOTE_INDICATOR && !O_SPOLL;
  endproperty
  a_ifc_idle: assert property (p_ifc_idle) else $error("not idle after clear");
  property p_ifc_keep;
    I_IFC && !I_ADDR_LOAD && !I_LANG_ENTER |=>
      $stable(O_ADDR) && $stable(O_LEGACY_DEVICE_COMMAND_SET);
  endproperty
  a_ifc_keep: assert property (p_ifc_keep) else $error("settings lost on clear");
  property p_dev_clear;
    O_DEV_CLEAR |-> $past(I_CMD_TAKE, 2) && ($past(I_DIO, 2) == {3'h0, grl_pkg::CMD_DCL} ||
      $past(I_DIO, 2) == {3'h0, grl_pkg::CMD_SDC} && $past(O_LISTEN_INDICATOR));
  endproperty
  a_dev_clear: assert property (p_dev_clear) else $error("stray device clear");
  property p_trigger;
    O_TRIGGER |-> $past(I_CMD_TAKE, 2) && $past(I_DIO, 2) == {3'h0, grl_pkg::CMD_GET} &&
      $past(I_TRIG_SRC_BUS) && $past(O_LISTEN_INDICATOR);
  endproperty
  a_trigger: assert property (p_trigger) else $error("stray trigger");
  property p_lang_new;
    I_LANG_ENTER && lang_diff |=> O_LEGACY_DEVICE_COMMAND_SET == $past(I_LANG_PICK) ##0 s_por;
  endproperty
  a_lang_new: assert property (p_lang_new) else $error("language change without reset");
  property p_lang_same;
    I_LANG_ENTER && !lang_diff |=> !O_POWERON_RESET && $stable(O_LEGACY_DEVICE_COMMAND_SET);
  endproperty
  a_lang_same: assert property (p_lang_same) else $error("reset on same language");
  property p_reset;
    $past(I_RST) |-> O_ADDR == grl_pkg::DEFAULT_ADDR && !O_REMOTE_INDICATOR && !O_LOCKOUT;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
endmodule : grl_props

// *** tb/grl_ctrl_model.sv ***
// Bus controller model: drives the bus pins and accepts talker bytes
`timescale 1ns/100ps
module grl_ctrl_model (
  input wire logic i_clk, // System clock
  input wire logic i_tx_valid, // Byte offered by device
  input wire logic [7:0] i_tx_data, // Offered byte
  output logic o_atn = 1'b0, // Attention
  output logic o_ren = 1'b0, // Remote enable
  output logic o_ifc = 1'b0, // Interface clear
  output logic o_take = 1'b0, // Byte accepted strobe
  output logic [7:0] o_dio = 8'h00, // Bus byte
  output logic o_tx_ready = 1'b0 // Ready to accept
);
  // All tasks start and end at a falling edge
  task automatic cmd(input logic [7:0] b);
    if (!o_atn) begin
      o_atn = 1'b1;
      repeat (3) @(negedge i_clk);
    end
    o_take = 1'b1;
    o_dio = b;
    @(negedge i_clk);
    o_take = 1'b0;
    o_dio = 8'h00; // Terminated lines read false once released
    repeat (2) @(negedge i_clk);
  endtask : cmd
  task automatic set_ren(input logic v);
    o_ren = v;
    repeat (3) @(negedge i_clk);
  endtask : set_ren
  task automatic atn_off;
    o_atn = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : atn_off
  task automatic pulse_ifc(input int n);
    o_ifc = 1'b1;
    repeat (n) @(negedge i_clk);
    o_ifc = 1'b0;
    repeat (4) @(negedge i_clk);
  endtask : pulse_ifc
  task automatic fetch(output logic [7:0] b);
    int n;
    o_tx_ready = 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (i_tx_valid === 1'b1) break;
    end
    if (n < 20) b = i_tx_data;
    @(negedge i_clk);
    o_tx_ready = 1'b0;
  endtask : fetch
endmodule : grl_ctrl_model

// *** tb/grl_remote_local_test.sv ***
// Testbench: remote/local control of the parallel bus port
`timescale 1ns/100ps
module grl_remote_local_test;
  typedef struct packed {logic [7:0] dio; logic ren; logic [3:0] flags;} grl_row_t;
  logic clk;
  logic rst;
  logic atn, ren, ifc, take, resp_ready, tx_valid, tx_ready, remote, listen, talk, lock;
  logic spoll, dclr, trig, legacy, por;
  logic addr_load, lang_enter, lang_pick, trig_src;
  logic resp_valid;
  logic [7:0] dio, tx_data, rx, status, resp_data;
  logic [4:0] addr, addr_new;
  logic [11:0] keys, keys_en, kq;
  int miscompares = 0, total_checks = 0, cyc = 0, n_clr = 0, n_trg = 0, i, c0, t0;
  wire logic [3:0] flags = {remote, lock, listen, talk};
  // Flags: remote, lockout, listen, talk
  // Last row: another device's talk address untalks us
  grl_row_t rows [11] = '{'{8'h3B, 1'b0, 4'h2}, '{8'h3F, 1'b0, 4'h0}, '{8'h5B, 1'b1, 4'h1},
    '{8'h3B, 1'b1, 4'hA}, '{8'h11, 1'b1, 4'hE}, '{8'h01, 1'b1, 4'h2}, '{8'h3B, 1'b1, 4'hA},
    '{8'h5B, 1'b1, 4'h9}, '{8'h5F, 1'b1, 4'h8}, '{8'h5B, 1'b1, 4'h9}, '{8'h45, 1'b1, 4'h8}};
  always #25 clk = ~clk;
  grl_remote_local DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_ATN(atn), .I_REN(ren), .I_IFC(ifc),
    .I_CMD_TAKE(take), .I_DIO(dio), .I_ADDR_LOAD(addr_load), .I_ADDR_NEW(addr_new),
    .I_PANEL_KEYS(keys), .I_LANG_ENTER(lang_enter), .I_LANG_PICK(lang_pick),
    .I_TRIG_SRC_BUS(trig_src), .I_STATUS_BYTE(status), .I_RESP_DATA(resp_data),
    .I_RESP_VALID(resp_valid), .I_TX_READY(tx_ready), .O_RESP_READY(resp_ready),
    .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid), .O_KEYS_EN(keys_en),
    .O_REMOTE_INDICATOR(remote), .O_TALK_INDICATOR(talk), .O_LISTEN_INDICATOR(listen),
    .O_LOCKOUT(lock), .O_SPOLL(spoll), .O_DEV_CLEAR(dclr), .O_TRIGGER(trig),
    .O_LEGACY_DEVICE_COMMAND_SET(legacy), .O_POWERON_RESET(por), .O_ADDR(addr));
  grl_ctrl_model u_ctl (.i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_atn(atn),
    .o_ren(ren), .o_ifc(ifc), .o_take(take), .o_dio(dio), .o_tx_ready(tx_ready));
  task automatic chk_flags(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t flags %b exp %b", $time, got, exp);
    end
  endtask : chk_flags
  task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t value %h exp %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic press(input logic [11:0] k);
    keys = k;
    @(negedge clk);
    kq = keys_en;
    keys = 12'h000;
    repeat (2) @(negedge clk);
  endtask : press
  task automatic pcmd(input logic [7:0] b, input int ec, input int et);
    c0 = n_clr;
    t0 = n_trg;
    u_ctl.cmd(b);
    chk_val(12'(n_clr - c0), 12'(ec));
    chk_val(12'(n_trg - t0), 12'(et));
  endtask : pcmd
  task automatic offer(input logic [7:0] b);
    resp_data = b;
    resp_valid = 1'b1;
    for (i = 0; i < 20; i++) begin
      #1;
      if (resp_ready === 1'b1) break;
      @(negedge clk);
    end
    @(negedge clk);
    resp_valid = 1'b0;
  endtask : offer
  always @(posedge clk) begin
    cyc++;
    if (dclr === 1'b1) n_clr++;
    if (trig === 1'b1) n_trg++;
    if (cyc == 12000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    addr_load = 1'b0;
    lang_enter = 1'b0;
    lang_pick = 1'b0;
    trig_src = 1'b0;
    resp_valid = 1'b0;
    status = 8'hA5;
    resp_data = 8'h00;
    addr_new = 5'h00;
    keys = 12'h000;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_val(12'(addr), 12'd27);
    chk_flags(flags, 4'h0);
    for (i = 0; i < 11; i++) begin
      if (ren !== rows[i].ren) u_ctl.set_ren(rows[i].ren);
      u_ctl.cmd(rows[i].dio);
      chk_flags(flags, rows[i].flags);
    end
    $display("end of command table at %0t", $time);
    // Local key left out so that remote must hold
    press(12'hFFE);
    chk_val(kq, 12'h000);
    chk_flags(flags, 4'h8);
    press(12'h001);
    chk_val(kq, 12'h001);
    chk_flags(flags, 4'h0);
    press(12'hFFF);
    chk_val(kq, 12'hFFF);
    u_ctl.cmd(8'h3B);
    u_ctl.cmd(8'h11);
    press(12'h001);
    chk_flags(flags, 4'hE);
    chk_val(kq, 12'h000);
    $display("end of key test at %0t", $time);
    u_ctl.pulse_ifc(100);
    chk_flags(flags, 4'hE);
    u_ctl.pulse_ifc(grl_pkg::IFC_CYCLES + 10);
    chk_flags(flags, 4'h4);
    chk_val({addr, 6'h00, legacy}, {5'd27, 7'h00});
    u_ctl.cmd(8'h3B);
    u_ctl.cmd(8'h01);
    chk_flags(flags, 4'h2);
    $display("end of clear test at %0t", $time);
    u_ctl.cmd(8'h3F);
    pcmd(8'h04, 0, 0);
    pcmd(8'h14, 1, 0);
    u_ctl.cmd(8'h3B);
    pcmd(8'h04, 1, 0);
    trig_src = 1'b1;
    pcmd(8'h08, 0, 1);
    trig_src = 1'b0;
    pcmd(8'h08, 0, 0);
    $display("end of device clear test at %0t", $time);
    u_ctl.set_ren(1'b0);
    u_ctl.cmd(8'h5B);
    u_ctl.atn_off();
    offer(8'h0D);
    u_ctl.fetch(rx);
    chk_val(12'(rx), 12'h00D);
    offer(8'h0A);
    u_ctl.fetch(rx);
    chk_val(12'(rx), 12'h00A);
    u_ctl.cmd(8'h18);
    u_ctl.atn_off();
    u_ctl.fetch(rx);
    chk_val({3'h0, spoll, rx}, 12'h1A5);
    u_ctl.cmd(8'h19);
    chk_val(12'(spoll), 12'h000);
    $display("end of talk test at %0t", $time);
    addr_new = 5'h05;
    addr_load = 1'b1;
    @(negedge clk);
    addr_load = 1'b0;
    @(negedge clk);
    chk_val(12'(addr), 12'h005);
    // Talker before each pick: only a real change may drop it
    for (i = 0; i < 2; i++) begin
      u_ctl.cmd(8'h45);
      lang_pick = 1'b1;
      lang_enter = 1'b1;
      @(negedge clk);
      lang_enter = 1'b0;
      repeat (2) @(negedge clk);
      chk_val({3'h0, legacy, 4'h0, flags}, 12'h100 | 12'(i));
    end
    $display("end of language test at %0t", $time);
    print_verdict;
  end
endmodule : grl_remote_local_test
bind grl_remote_local grl_props u_props (.*);
